/* rtl/nnora_pkg.sv */
// Purpose: Shared constants and types for the negate/not/or/rotate datapath
// Assumes: 16-bit instruction words, 32-bit general registers
// Notes:   Opcode classes are matched as (word & mask) == match
package nnora_pkg;

  localparam int unsigned DATA_W  = 32;
  localparam int unsigned INSN_W  = 16;
  localparam int unsigned NREGS   = 16;
  localparam int unsigned IDX_W   = 4;

  // Opcode masks and match values
  localparam logic [15:0] MASK_RR     = 16'hf00f;
  localparam logic [15:0] MASK_R      = 16'hf0ff;
  localparam logic [15:0] MASK_IMM    = 16'hff00;
  localparam logic [15:0] MASK_ALL    = 16'hffff;
  localparam logic [15:0] OP_MULU     = 16'h200e;
  localparam logic [15:0] OP_NEG      = 16'h600b;
  localparam logic [15:0] OP_COMPLEMENT_WITH_BORROW_OP     = 16'h600a;
  localparam logic [15:0] OP_NOP      = 16'h0009;
  localparam logic [15:0] OP_NOT      = 16'h6007;
  localparam logic [15:0] OP_OR_RR    = 16'h200b;
  localparam logic [15:0] OP_OR_IMM   = 16'hcb00;
  localparam logic [15:0] OP_OR_BYTE  = 16'hcf00;
  localparam logic [15:0] OP_ROTL_F   = 16'h4024;
  localparam logic [15:0] OP_ROTR_F   = 16'h4025;

  // Field positions inside the instruction word
  localparam int unsigned DST_LSB     = 8;
  localparam int unsigned SRC_LSB     = 4;
  localparam int unsigned IMM_LSB     = 0;

  // Status word layout and program counter step
  localparam int unsigned FLAG_BIT    = 0;
  localparam logic [31:0] PC_STEP     = 32'h0000_0002;

  // Values after reset
  localparam logic [31:0] RST_PC      = 32'h0000_0000;
  localparam logic [31:0] RST_WORD    = 32'h0000_0000;

  // Byte read-modify-write sequence
  typedef enum logic [2:0] {
    NNORA_IDLE = 3'b001,
    NNORA_READ = 3'b010,
    NNORA_WRIT = 3'b100
  } nnora_state_t;

endpackage

/* rtl/nnora_alu.sv */
// Purpose: Execution datapath for negate, complement, or, rotate-through-flag
//          and unsigned halfword multiply instructions
// Assumes: Data memory answers a read combinationally in the strobe cycle
// Notes:   Overview of operation follows; one instruction accepted when ready
//
// Overview of operation
// - Multiply low halfwords unsigned into product_low
// - Flag is bit 0 of status word
// - Negate: zero minus source, flag kept
// - Borrow negate: zero minus source minus flag
// - Borrow negate flag from both borrows
// - No-operation only advances program counter
// - Complement: invert source into destination
// - Register OR into destination, flag kept
// - Immediate OR into register zero
// - Byte OR at base plus index, three cycles
// - Rotate left through flag
// - Rotate right through flag
`timescale 1ns/1ps
`default_nettype none

module nnora_alu (
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  // Instruction from decode
  input  wire logic        insn_valid,
  input  wire logic [15:0] insn_word,
  output logic             insn_ready,
  output logic             retire_r,
  output logic             illegal_r,
  // Writes from the rest of the core
  input  wire logic        ext_reg_we,
  input  wire logic [3:0]  ext_reg_idx,
  input  wire logic [31:0] ext_reg_data,
  input  wire logic        ext_base_we,
  input  wire logic [31:0] ext_base_data,
  input  wire logic        ext_pc_we,
  input  wire logic [31:0] ext_pc_data,
  // State visible to the core
  input  wire logic [3:0]  obs_reg_idx,
  output logic [31:0]      obs_reg_data_r,
  output logic [31:0]      pc_r,
  output logic [31:0]      status_word_r,
  output logic [31:0]      product_low_r,
  output logic [31:0]      product_high_r,
  // Data memory bus, byte wide
  output logic             mem_rd,
  output logic             mem_wr,
  output logic [31:0]      mem_addr_r,
  output logic [7:0]       mem_wdata_r,
  input  wire logic [7:0]  mem_rdata
);

  // Opcode class test, used for every decode
  function automatic logic op_is(input logic [15:0] w,
                                 input logic [15:0] mask,
                                 input logic [15:0] match);
    op_is = ((w & mask) == match);
  endfunction

  logic [31:0]         gpr_r [nnora_pkg::NREGS];
  logic [31:0]         gpr_nxt [nnora_pkg::NREGS];
  logic [31:0]         base_r;
  logic [31:0]         base_nxt;
  logic [31:0]         pc_nxt;
  logic [31:0]         status_word_nxt;
  logic [31:0]         product_low_nxt;
  logic [31:0]         obs_reg_data_nxt;
  logic                retire_nxt;
  logic                illegal_nxt;
  logic [31:0]         mem_addr_nxt;
  logic [7:0]          mem_wdata_nxt;
  logic [7:0]          imm_r;
  logic [7:0]          imm_nxt;
  nnora_pkg::nnora_state_t state_r;
  nnora_pkg::nnora_state_t state_nxt;

  logic [3:0]          dst;
  logic [3:0]          src;
  logic [7:0]          imm;
  logic [31:0]         rd_val;
  logic [31:0]         rs_val;
  logic                flag;
  logic [31:0]         neg_tmp;
  logic [31:0]         complement_with_borrow_op_res;
  logic                take;

  // Field extraction and operand fetch
  assign dst     = insn_word[nnora_pkg::DST_LSB +: 4];
  assign src     = insn_word[nnora_pkg::SRC_LSB +: 4];
  assign imm     = insn_word[nnora_pkg::IMM_LSB +: 8];
  assign rd_val  = gpr_r[dst];
  assign rs_val  = gpr_r[src];
  assign flag    = status_word_r[nnora_pkg::FLAG_BIT];
  assign neg_tmp  = 32'h0000_0000 - rs_val;
  assign complement_with_borrow_op_res = neg_tmp - {31'h0000_0000, flag};
  assign take    = insn_valid && insn_ready;

  // Handshake outputs follow the sequencer state
  assign insn_ready = (state_r == nnora_pkg::NNORA_IDLE);
  assign mem_rd     = (state_r == nnora_pkg::NNORA_READ);
  assign mem_wr     = (state_r == nnora_pkg::NNORA_WRIT);

  // Next state of registers, flag, counter and byte sequence
  always_comb begin
    for (int i = 0; i < nnora_pkg::NREGS; i++) begin
      gpr_nxt[i] = gpr_r[i];
    end
    base_nxt         = base_r;
    pc_nxt           = pc_r;
    status_word_nxt  = status_word_r;
    product_low_nxt  = product_low_r;
    retire_nxt       = 1'b0;
    illegal_nxt      = 1'b0;
    mem_addr_nxt     = mem_addr_r;
    mem_wdata_nxt    = mem_wdata_r;
    imm_nxt          = imm_r;
    state_nxt        = state_r;
    case (state_r)
      nnora_pkg::NNORA_IDLE: begin
        if (take) begin
          retire_nxt = 1'b1;
          pc_nxt     = pc_r + nnora_pkg::PC_STEP;
          if (op_is(insn_word, nnora_pkg::MASK_RR, nnora_pkg::OP_MULU)) begin
            product_low_nxt = {16'h0000, rd_val[15:0]}
                            * {16'h0000, rs_val[15:0]};
          end else if (op_is(insn_word, nnora_pkg::MASK_RR,
                             nnora_pkg::OP_NEG)) begin
            gpr_nxt[dst] = neg_tmp;
          end else if (op_is(insn_word, nnora_pkg::MASK_RR,
                             nnora_pkg::OP_COMPLEMENT_WITH_BORROW_OP)) begin
            gpr_nxt[dst] = complement_with_borrow_op_res;
            status_word_nxt[nnora_pkg::FLAG_BIT] =
              (neg_tmp != 32'h0000_0000) || (neg_tmp < complement_with_borrow_op_res);
          end else if (op_is(insn_word, nnora_pkg::MASK_ALL,
                             nnora_pkg::OP_NOP)) begin
            pc_nxt = pc_r + nnora_pkg::PC_STEP;
          end else if (op_is(insn_word, nnora_pkg::MASK_RR,
                             nnora_pkg::OP_NOT)) begin
            gpr_nxt[dst] = ~rs_val;
          end else if (op_is(insn_word, nnora_pkg::MASK_RR,
                             nnora_pkg::OP_OR_RR)) begin
            gpr_nxt[dst] = rd_val | rs_val;
          end else if (op_is(insn_word, nnora_pkg::MASK_IMM,
                             nnora_pkg::OP_OR_IMM)) begin
            gpr_nxt[0] = gpr_r[0] | {24'h00_0000, imm};
          end else if (op_is(insn_word, nnora_pkg::MASK_IMM,
                             nnora_pkg::OP_OR_BYTE)) begin
            // Hold retirement and counter until the write-back cycle
            retire_nxt   = 1'b0;
            pc_nxt       = pc_r;
            mem_addr_nxt = gpr_r[0] + base_r;
            imm_nxt      = imm;
            state_nxt    = nnora_pkg::NNORA_READ;
          end else if (op_is(insn_word, nnora_pkg::MASK_R,
                             nnora_pkg::OP_ROTL_F)) begin
            gpr_nxt[dst] = {rd_val[30:0], flag};
            status_word_nxt[nnora_pkg::FLAG_BIT] = rd_val[31];
          end else if (op_is(insn_word, nnora_pkg::MASK_R,
                             nnora_pkg::OP_ROTR_F)) begin
            gpr_nxt[dst] = {flag, rd_val[31:1]};
            status_word_nxt[nnora_pkg::FLAG_BIT] = rd_val[0];
          end else begin
            // Not in this group: refuse, nothing changes
            retire_nxt  = 1'b0;
            illegal_nxt = 1'b1;
            pc_nxt      = pc_r;
          end
        end
      end
      nnora_pkg::NNORA_READ: begin
        mem_wdata_nxt = mem_rdata | imm_r;
        state_nxt     = nnora_pkg::NNORA_WRIT;
      end
      nnora_pkg::NNORA_WRIT: begin
        retire_nxt = 1'b1;
        pc_nxt     = pc_r + nnora_pkg::PC_STEP;
        state_nxt  = nnora_pkg::NNORA_IDLE;
      end
      default: begin
        state_nxt = nnora_pkg::NNORA_IDLE;
      end
    endcase
    // Core writes override the datapath in the same cycle
    if (ext_reg_we) begin
      gpr_nxt[ext_reg_idx] = ext_reg_data;
    end
    if (ext_base_we) begin
      base_nxt = ext_base_data;
    end
    if (ext_pc_we) begin
      pc_nxt = ext_pc_data;
    end
    obs_reg_data_nxt = gpr_nxt[obs_reg_idx];
  end

  // Register stage for all state
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < nnora_pkg::NREGS; i++) begin
        gpr_r[i] <= nnora_pkg::RST_WORD;
      end
      base_r         <= nnora_pkg::RST_WORD;
      pc_r           <= nnora_pkg::RST_PC;
      status_word_r  <= nnora_pkg::RST_WORD;
      product_low_r  <= nnora_pkg::RST_WORD;
      obs_reg_data_r <= nnora_pkg::RST_WORD;
      retire_r       <= 1'b0;
      illegal_r      <= 1'b0;
      mem_addr_r     <= nnora_pkg::RST_WORD;
      mem_wdata_r    <= 8'h00;
      imm_r          <= 8'h00;
      state_r        <= nnora_pkg::NNORA_IDLE;
    end else begin
      for (int i = 0; i < nnora_pkg::NREGS; i++) begin
        gpr_r[i] <= gpr_nxt[i];
      end
      base_r         <= base_nxt;
      pc_r           <= pc_nxt;
      status_word_r  <= status_word_nxt;
      product_low_r  <= product_low_nxt;
      obs_reg_data_r <= obs_reg_data_nxt;
      retire_r       <= retire_nxt;
      illegal_r      <= illegal_nxt;
      mem_addr_r     <= mem_addr_nxt;
      mem_wdata_r    <= mem_wdata_nxt;
      imm_r          <= imm_nxt;
      state_r        <= state_nxt;
    end
  end

  // High product half is never written by this group
  assign product_high_r = nnora_pkg::RST_WORD;

endmodule

`default_nettype wire

/* tb/nnora_mem_model.sv */
// Purpose: Byte data memory on the far side of the byte OR sequence
// Assumes: Read data is given in the same cycle as mem_rd
// Notes:   Every byte starts as a5
`timescale 1ns/1ps
`default_nettype none
module nnora_mem_model (
  input  wire logic        core_clk,
  input  wire logic        mem_rd,
  input  wire logic        mem_wr,
  input  wire logic [31:0] mem_addr_r,
  input  wire logic [7:0]  mem_wdata_r,
  output logic [7:0]       mem_rdata
);
  logic [7:0] mem [256];
  logic [7:0] last;
  initial begin
    last = 8'h00;
    foreach (mem[i]) mem[i] = 8'ha5;
  end
  // Outside a read the bus shows the inverse of the last byte
  assign mem_rdata = mem_rd ? mem[mem_addr_r[7:0]] : ~last;
  // Remember the read byte and store the written byte
  always @(posedge core_clk) begin
    if (mem_rd) last <= mem[mem_addr_r[7:0]];
    if (mem_wr) mem[mem_addr_r[7:0]] <= mem_wdata_r;
  end
endmodule
`default_nettype wire

/* tb/nnora_alu_checker.sv */
// Purpose: Port-level assertions for the datapath
// Assumes: Bound to every instance of nnora_alu
// Notes:   One clock domain, reset disables all checks
`timescale 1ns/1ps
`default_nettype none
module nnora_alu_checker (
  input wire logic        core_clk,
  input wire logic        arst_n,
  input wire logic        insn_valid,
  input wire logic [15:0] insn_word,
  input wire logic        insn_ready,
  input wire logic        retire_r,
  input wire logic        illegal_r,
  input wire logic        ext_pc_we,
  input wire logic [31:0] pc_r,
  input wire logic [31:0] status_word_r,
  input wire logic [31:0] product_high_r,
  input wire logic        mem_rd,
  input wire logic        mem_wr
);
  logic take;
  logic take_b;
  // Instruction taken, and taken as byte OR
  assign take = insn_valid && insn_ready;
  assign take_b = take && ((insn_word & nnora_pkg::MASK_IMM)
                  == nnora_pkg::OP_OR_BYTE);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  chk_byte_busy:
    assert property (take_b |=> !insn_ready [*2] ##1 insn_ready)
    else $error("byte or busy window wrong");
  chk_byte_bus:
    assert property (take_b |=> mem_rd && !mem_wr ##1 mem_wr && !mem_rd
      ##1 retire_r) else $error("byte or bus order wrong");
  chk_pc_step:
    assert property (retire_r && !$past(ext_pc_we)
      |-> pc_r == $past(pc_r) + nnora_pkg::PC_STEP)
    else $error("pc not advanced by two");
  chk_illegal_pc:
    assert property (illegal_r && !$past(ext_pc_we) |-> $stable(pc_r))
    else $error("illegal word moved pc");
  chk_neg_flag:
    assert property (take && ((insn_word & nnora_pkg::MASK_RR)
      == nnora_pkg::OP_NEG) |=> $stable(status_word_r))
    else $error("negate changed flag");
  chk_nop_only:
    assert property (take && insn_word == nnora_pkg::OP_NOP && !ext_pc_we
      |=> retire_r && $stable(status_word_r)
      && pc_r == $past(pc_r) + nnora_pkg::PC_STEP)
    else $error("no-operation misbehaved");
  chk_one_cycle:
    assert property (take && !take_b |=> retire_r != illegal_r)
    else $error("single op not done in one cycle");
  chk_high_kept:
    assert property ($stable(product_high_r))
    else $error("high product changed");
  chk_status_bits:
    assert property (status_word_r[31:1] == 31'h0)
    else $error("status word upper bits set");
  cov_byte: cover property (take_b);
  cov_illegal: cover property (illegal_r);
  cov_flag_set: cover property ($rose(status_word_r[0]));
endmodule
bind nnora_alu nnora_alu_checker chk (.core_clk, .arst_n, .insn_valid,
  .insn_word, .insn_ready, .retire_r, .illegal_r, .ext_pc_we, .pc_r,
  .status_word_r, .product_high_r, .mem_rd, .mem_wr);
`default_nettype wire

/* tb/tb_top.sv */
// Purpose: Self-checking bench for the datapath
// Assumes: Inputs change at the falling edge
// Notes:   Memory model answers the byte OR sequence
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        core_clk, arst_n, insn_valid, insn_ready, retire_r;
  logic        illegal_r, ext_reg_we, ext_base_we, ext_pc_we;
  logic        mem_rd, mem_wr;
  logic [15:0] insn_word;
  logic [3:0]  ext_reg_idx, obs_reg_idx;
  logic [31:0] ext_reg_data, ext_base_data, ext_pc_data, obs_reg_data_r;
  logic [31:0] pc_r, status_word_r, product_low_r, product_high_r;
  logic [31:0] mem_addr_r;
  logic [7:0]  mem_wdata_r, mem_rdata;
  logic        ill_seen;
  int          num_errors, comparisons;
  nnora_alu dut (.core_clk, .arst_n, .insn_valid, .insn_word, .insn_ready,
    .retire_r, .illegal_r, .ext_reg_we, .ext_reg_idx, .ext_reg_data,
    .ext_base_we, .ext_base_data, .ext_pc_we, .ext_pc_data, .obs_reg_idx,
    .obs_reg_data_r, .pc_r, .status_word_r, .product_low_r,
    .product_high_r, .mem_rd, .mem_wr, .mem_addr_r, .mem_wdata_r,
    .mem_rdata);
  nnora_mem_model mm (.core_clk, .mem_rd, .mem_wr, .mem_addr_r,
    .mem_wdata_r, .mem_rdata);
  // Clock at 4 ns
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic setr(input logic [3:0] i, input logic [31:0] v);
    ext_reg_we = 1'b1;
    ext_reg_idx = i;
    ext_reg_data = v;
    @(negedge core_clk);
    ext_reg_we = 1'b0;
    // Let an edge pass so a following call never re-raises the strobe at once
    @(negedge core_clk);
  endtask
  task automatic getr(input logic [3:0] i, input logic [31:0] exp);
    obs_reg_idx = i;
    @(negedge core_clk);
    chk(obs_reg_data_r, exp);
  endtask
  // Offer one word, count cycles to completion
  task automatic exec(input logic [15:0] w, input int cyc);
    int n;
    n = 0;
    insn_valid = 1'b1;
    insn_word = w;
    do begin
      @(negedge core_clk);
      insn_valid = 1'b0;
      n++;
    end while (!(retire_r || illegal_r) && n < 8);
    ill_seen = illegal_r;
    chk(32'(n), 32'(cyc));
    // Let an edge pass so a following call never re-raises valid at once
    @(negedge core_clk);
  endtask
  task automatic t_mulu();
    setr(4'h0, 32'h00000002);
    setr(4'h1, 32'hffffaaaa);
    exec(16'h210e, 1);
    chk(product_low_r, 32'h00015554);
    chk(product_high_r, 32'h0);
    $display("test mulu done");
  endtask
  task automatic t_neg();
    setr(4'h0, 32'h00000001);
    exec(16'h610b, 1);
    getr(4'h1, 32'hffffffff);
    $display("test neg done");
  endtask
  task automatic t_complement_with_borrow_op();
    exec(16'h4225, 1);
    setr(4'h2, 32'h0);
    setr(4'h1, 32'h1);
    setr(4'h0, 32'h0);
    exec(16'h622a, 1);
    chk(status_word_r, 32'h0);
    getr(4'h2, 32'h0);
    exec(16'h611a, 1);
    chk(status_word_r, 32'h1);
    exec(16'h600a, 1);
    chk(status_word_r, 32'h1);
    getr(4'h1, 32'hffffffff);
    getr(4'h0, 32'hffffffff);
    $display("test complement_with_borrow_op done");
  endtask
  task automatic t_rot();
    setr(4'h3, 32'h40000000);
    exec(16'h4324, 1);
    chk(status_word_r, 32'h0);
    getr(4'h3, 32'h80000001);
    exec(16'h4325, 1);
    chk(status_word_r, 32'h1);
    getr(4'h3, 32'h40000000);
    $display("test rotate done");
  endtask
  task automatic t_logic();
    setr(4'h0, 32'haaaaaaaa);
    exec(16'h6107, 1);
    getr(4'h1, 32'h55555555);
    setr(4'h0, 32'haaaa5555);
    setr(4'h1, 32'h55550000);
    exec(16'h210b, 1);
    getr(4'h1, 32'hffff5555);
    setr(4'h0, 32'h00000008);
    exec(16'hcbf0, 1);
    getr(4'h0, 32'h000000f8);
    $display("test logic done");
  endtask
  task automatic t_nop();
    ext_pc_we = 1'b1;
    ext_pc_data = 32'h00000100;
    @(negedge core_clk);
    ext_pc_we = 1'b0;
    exec(16'h0009, 1);
    chk({31'h0, ill_seen}, 32'h0);
    chk(pc_r, 32'h00000102);
    exec(16'hffff, 1);
    chk({31'h0, ill_seen}, 32'h1);
    chk(pc_r, 32'h00000102);
    $display("test nop done");
  endtask
  task automatic t_byte();
    ext_base_we = 1'b1;
    ext_base_data = 32'h00000100;
    setr(4'h0, 32'h00000020);
    ext_base_we = 1'b0;
    exec(16'hcf50, 3);
    chk(mem_addr_r, 32'h00000120);
    chk({24'h0, mm.mem[8'h20]}, 32'h000000f5);
    chk(pc_r, 32'h00000104);
    $display("test byte or done");
  endtask
  task automatic results();
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Watchdog
  initial begin
    #8000;
    num_errors++;
    $display("ERROR %0t watchdog expired", $time);
    results();
  end
  // Main sequence
  initial begin
    {arst_n, insn_valid, ext_reg_we, ext_base_we, ext_pc_we} = 5'h0;
    {insn_word, ext_reg_idx, obs_reg_idx} = 24'h0;
    {ext_reg_data, ext_base_data, ext_pc_data} = 96'h0;
    num_errors = 0;
    comparisons = 0;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    arst_n = 1'b1;
    t_mulu();
    t_neg();
    t_complement_with_borrow_op();
    t_rot();
    t_logic();
    t_nop();
    t_byte();
    results();
  end
endmodule
`default_nettype wire
